// >>> hw/fpu_exc_pkg.sv
// types shared by the coprocessor exception block
package fpu_exc_pkg;
    // destination formats of a result in memory
    typedef enum logic [2:0] {
        FMT_SINGLE   = 3'b000,
        FMT_DOUBLE   = 3'b001,
        FMT_EXTENDED = 3'b010,
        FMT_INT16    = 3'b011,
        FMT_INT32    = 3'b100,
        FMT_INT64    = 3'b101,
        FMT_BCD      = 3'b110
    } fmt_t;

    // exception classes, numbered in order of precedence
    typedef enum logic [2:0] {
        EXC_NONE     = 3'b000,
        EXC_INVALID  = 3'b001,
        EXC_DENORM   = 3'b010,
        EXC_ZERODIV  = 3'b011,
        EXC_OVERFLOW = 3'b100,
        EXC_UNDERFL  = 3'b101,
        EXC_INEXACT  = 3'b110
    } exc_t;

    // whole state of the block
    typedef struct packed {
        logic [15:0] cw;
        logic [15:0] sw;
        logic [15:0] tw;
        logic [31:0] ip;
        logic [31:0] dp;
        logic [31:0] rdata;
        logic        exc_valid;
        exc_t        exc_code;
        exc_t        last_exc;
        logic        use_default;
        logic [79:0] default_val;
        logic        error_b;
    } state_t;
endpackage : fpu_exc_pkg

// >>> hw/fpu_exc_regs.svh
// constants for the coprocessor exception and initialisation block
// Function
// - exponent biases 127, 1023, 16383 per precision
// - ignore don't-care bits on load, store zeros
// - sign 0 positive; BCD two digits per byte
// - integer bit explicit only in extended format
// - invalid on SNaN, unsupported, indeterminate, stack fault
// - masked invalid gives NaN or integer/BCD indefinite
// - denormal operand flagged; masked continues normally
// - finite nonzero divided by zero; masked gives infinity
// - overflow flagged; masked gives max finite or infinity
// - underflow flagged; masked only when accuracy lost
// - inexact flagged; masked rounds and continues
// - initialise loads control word 037F; hardware reset loads 037E
// - infinity control bit zero, affine always
// - initialise clears exception flags and busy bit
// - initialise sets stack top to zero
// - initialise sets tag word to all empty
// - hardware reset sets invalid, summary, clears invalid mask
// - unmasked exception keeps instruction and operand addresses
// - aborted instruction leaves pointers on previous instruction
// - behaviour independent of host addressing mode
// - precedence invalid, denormal, zdiv, overflow, underflow, inexact
// - unmasked exception sets flag, summary, error output
`ifndef FPU_EXC_REGS_SVH
`define FPU_EXC_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_TAG       8'h08
`define OFS_INSTR_PTR 8'h0C
`define OFS_DATA_PTR  8'h10
`define OFS_COMMAND   8'h14
`define OFS_LAST_EXC  8'h18

// ---------------------------------------------------------------
// field positions and values
// ---------------------------------------------------------------
`define SW_STACK_FAULT 6
`define SW_ERR_SUM     7
`define SW_C1          9
`define SW_TOP_LO      11
`define SW_BUSY        15
`define CW_RC_LO       10
`define CMD_INIT       0
`define CMD_CLEAR      1
`define CW_INIT        16'h037F
`define CW_HW_RESET    16'h037E
`define SW_INIT        16'h0000
`define SW_HW_RESET    16'h0081
`define TW_INIT        16'hFFFF
`define BIAS_SINGLE    127
`define BIAS_DOUBLE    1023
`define BIAS_EXTENDED  16383

`endif

// >>> hw/fpu_exception_and_init_state.sv
// exception detection, masked defaults and initial architectural state of the coprocessor
`timescale 1ns/10ps
`include "fpu_exc_regs.svh"

module fpu_exception_and_init_state (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    // register port
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [31:0]        o_rdata,
    // completed operation from the datapath
    input  wire logic               i_op_valid,
    input  wire logic               i_op_abort,
    input  wire logic               i_op_div,
    input  wire logic               i_op_indet,
    input  wire logic               i_push,
    input  wire logic               i_pop,
    input  wire logic [79:0]        i_opnd_a,
    input  wire logic [79:0]        i_opnd_b,
    input  wire fpu_exc_pkg::fmt_t  i_dst_fmt,
    input  wire logic               i_res_sign,
    input  wire logic               i_res_huge,
    input  wire logic               i_res_tiny,
    input  wire logic               i_res_lossy,
    input  wire logic               i_res_inexact,
    input  wire logic [31:0]        i_instr_addr,
    input  wire logic [31:0]        i_oper_addr,
    input  wire logic               i_busy,
    // exception report
    output logic                    o_exc_valid,
    output fpu_exc_pkg::exc_t       o_exc_code,
    output logic                    o_use_default,
    output logic      [79:0]        o_default,
    output logic                    o_error_b
);
    import fpu_exc_pkg::*;

    // ---------------------------------------------------------------
    // operand classification (extended format)
    // ---------------------------------------------------------------
    function automatic logic exp_max(input logic [79:0] v);
        exp_max = (v[78:64] == 15'h7FFF);
    endfunction : exp_max

    // signalling NaN: all-ones exponent, integer bit set, quiet bit clear
    function automatic logic is_snan(input logic [79:0] v);
        is_snan = exp_max(v) && v[63] && !v[62] && (v[61:0] != 62'h0);
    endfunction : is_snan

    // unnormals, pseudo-NaNs and pseudo-infinities are unsupported encodings
    function automatic logic is_unsup(input logic [79:0] v);
        is_unsup = (v[78:64] != 15'h0000) && !v[63];
    endfunction : is_unsup

    function automatic logic is_zero(input logic [79:0] v);
        is_zero = (v[78:64] == 15'h0000) && (v[63:0] == 64'h0);
    endfunction : is_zero

    // smallest exponent with a nonzero significand
    function automatic logic is_denorm(input logic [79:0] v);
        is_denorm = (v[78:64] == 15'h0000) && (v[63:0] != 64'h0);
    endfunction : is_denorm

    // ---------------------------------------------------------------
    // masked default results, laid out as stored in memory
    // ---------------------------------------------------------------
    // unused upper bits are zero so narrow formats store clean
    function automatic logic [79:0] indefinite(input fmt_t fmt);
        case (fmt)
            FMT_SINGLE:   indefinite = {48'h0, 32'hFFC0_0000};
            FMT_DOUBLE:   indefinite = {16'h0, 64'hFFF8_0000_0000_0000};
            FMT_EXTENDED: indefinite = 80'hFFFF_C000_0000_0000_0000;
            FMT_INT16:    indefinite = {64'h0, 16'h8000};
            FMT_INT32:    indefinite = {48'h0, 32'h8000_0000};
            FMT_INT64:    indefinite = {16'h0, 64'h8000_0000_0000_0000};
            FMT_BCD:      indefinite = 80'hFFFF_C000_0000_0000_0000;
            default:      indefinite = 80'h0000_0000_0000_0000_0000;
        endcase
    endfunction : indefinite

    // infinity or largest finite value; exponents derive from the bias
    function automatic logic [79:0] big_value(input fmt_t fmt, input logic sign, input logic inf);
        logic [7:0]  e_s;
        logic [10:0] e_d;
        logic [14:0] e_x;
        e_s = 8'(2 * `BIAS_SINGLE + 32'(inf));
        e_d = 11'(2 * `BIAS_DOUBLE + 32'(inf));
        e_x = 15'(2 * `BIAS_EXTENDED + 32'(inf));
        case (fmt)
            // integer bit implied for single and double, so only the fraction is stored
            FMT_SINGLE:   big_value = {48'h0, sign, e_s, {23{!inf}}};
            FMT_DOUBLE:   big_value = {16'h0, sign, e_d, {52{!inf}}};
            FMT_EXTENDED: big_value = {sign, e_x, 1'b1, {63{!inf}}};
            default:      big_value = indefinite(fmt);
        endcase
    endfunction : big_value

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    state_t q;
    state_t d;

    // hardware reset image: invalid flagged and unmasked so the error pin marks presence
    localparam state_t RESET_STATE = '{
        cw:          `CW_HW_RESET,
        sw:          `SW_HW_RESET,
        tw:          `TW_INIT,
        ip:          32'h0000_0000,
        dp:          32'h0000_0000,
        rdata:       32'h0000_0000,
        exc_valid:   1'b0,
        exc_code:    EXC_NONE,
        last_exc:    EXC_NONE,
        use_default: 1'b0,
        default_val: 80'h0000_0000_0000_0000_0000,
        error_b:     1'b0
    };

    // ---------------------------------------------------------------
    // combinational helpers
    // ---------------------------------------------------------------
    logic [2:0] top_now;
    logic [2:0] top_dn;
    logic       stk_over;
    logic       stk_under;
    logic       op_go;
    logic       cmd_wr;
    logic       do_init;
    logic       do_clear;

    assign top_now  = q.sw[`SW_TOP_LO +: 3];
    assign top_dn   = 3'(top_now - 3'd1);
    assign op_go    = i_op_valid && !i_op_abort;
    assign cmd_wr   = i_wr && (i_addr == `OFS_COMMAND);
    assign do_init  = cmd_wr && i_wdata[`CMD_INIT];
    assign do_clear = cmd_wr && i_wdata[`CMD_CLEAR];
    // push onto a full slot or pop an empty one is a stack fault
    assign stk_over  = i_push && (q.tw[2*top_dn +: 2] != 2'b11);
    assign stk_under = i_pop && (q.tw[2*top_now +: 2] == 2'b11);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // host addressing mode never enters here; memory traffic is the host's job
    always_comb begin
        logic       inv;
        logic       den;
        logic       zdv;
        logic       ovf;
        logic       unf;
        logic       inx;
        logic       masked;
        logic [1:0] rc;
        logic [2:0] top_n;
        exc_t       code;
        inv    = 1'b0;
        den    = 1'b0;
        zdv    = 1'b0;
        ovf    = 1'b0;
        unf    = 1'b0;
        inx    = 1'b0;
        masked = 1'b0;
        rc     = 2'b00;
        top_n  = 3'b000;
        code   = EXC_NONE;
        d      = q;

        d.exc_valid   = 1'b0;
        d.use_default = 1'b0;
        d.rdata       = 32'h0000_0000;
        d.sw[`SW_BUSY] = i_busy;

        // register writes
        if (i_wr && (i_addr == `OFS_CTRL)) begin
            d.cw = i_wdata[15:0];                                           // bit 12 kept but never consulted
        end
        if (i_wr && (i_addr == `OFS_TAG)) begin
            d.tw = i_wdata[15:0];
        end
        // clearing the flags does not touch the pointers or the stack
        if (do_clear) begin
            d.sw[7:0]      = 8'h00;
            d.sw[`SW_BUSY] = 1'b0;
        end
        // initialise: condition codes deliberately left alone
        if (do_init) begin
            d.cw                     = `CW_INIT;
            d.sw[7:0]                = 8'h00;
            d.sw[`SW_BUSY]           = 1'b0;
            d.sw[`SW_TOP_LO +: 3]    = 3'b000;
            d.tw                     = `TW_INIT;
        end

        // classification; events are applied after the clears so a set wins
        if (op_go) begin
            inv = is_snan(i_opnd_a) || is_snan(i_opnd_b)
                || is_unsup(i_opnd_a) || is_unsup(i_opnd_b)
                || i_op_indet || stk_over || stk_under;
            den = is_denorm(i_opnd_a) || is_denorm(i_opnd_b);
            zdv = i_op_div && is_zero(i_opnd_b) && !is_zero(i_opnd_a)
                && !exp_max(i_opnd_a);
            ovf = i_res_huge;
            // masked underflow counts only when denormalising loses bits
            unf = i_res_tiny && (!d.cw[4] || i_res_lossy);
            inx = i_res_inexact;

            // fixed precedence picks one class to report
            if (inv) begin
                code = EXC_INVALID;
            end else if (den) begin
                code = EXC_DENORM;
            end else if (zdv) begin
                code = EXC_ZERODIV;
            end else if (ovf) begin
                code = EXC_OVERFLOW;
            end else if (unf) begin
                code = EXC_UNDERFL;
            end else if (inx) begin
                code = EXC_INEXACT;
            end else begin
                code = EXC_NONE;
            end

            // stack movement
            top_n = d.sw[`SW_TOP_LO +: 3];
            if (i_push && !stk_over) begin
                top_n             = 3'(top_n - 3'd1);
                d.tw[2*top_n +: 2] = 2'b00;
            end else if (i_pop && !stk_under) begin
                d.tw[2*top_n +: 2] = 2'b11;
                top_n             = 3'(top_n + 3'd1);
            end
            d.sw[`SW_TOP_LO +: 3] = top_n;

            if (code != EXC_NONE) begin
                masked = d.cw[code - EXC_INVALID];
                rc     = d.cw[`CW_RC_LO +: 2];
                d.sw[code - EXC_INVALID] = 1'b1;
                if (stk_over || stk_under) begin
                    d.sw[`SW_STACK_FAULT] = 1'b1;
                    d.sw[`SW_C1]          = stk_over;
                end
                if (!masked) begin
                    d.sw[`SW_ERR_SUM] = 1'b1;
                end
                d.exc_valid = 1'b1;
                d.exc_code  = code;
                d.last_exc  = code;
            end

            // masked defaults; the other classes let the datapath result stand
            if (masked) begin
                case (code)
                    EXC_INVALID: begin
                        d.use_default = 1'b1;
                        d.default_val = indefinite(i_dst_fmt);
                    end
                    EXC_ZERODIV: begin
                        d.use_default = 1'b1;
                        d.default_val = big_value(i_dst_fmt, i_opnd_a[79] ^ i_opnd_b[79], 1'b1);
                    end
                    EXC_OVERFLOW: begin
                        d.use_default = 1'b1;
                        // nearest gives infinity, chop the largest finite, directed modes by sign
                        case (rc)
                            2'b00:   d.default_val = big_value(i_dst_fmt, i_res_sign, 1'b1);
                            2'b01:   d.default_val = big_value(i_dst_fmt, i_res_sign, i_res_sign);
                            2'b10:   d.default_val = big_value(i_dst_fmt, i_res_sign, !i_res_sign);
                            default: d.default_val = big_value(i_dst_fmt, i_res_sign, 1'b0);
                        endcase
                    end
                    default: begin
                        d.use_default = 1'b0;
                    end
                endcase
            end

            // pointers track the last executed instruction, frozen once an error is pending
            if (!q.sw[`SW_ERR_SUM]) begin
                d.ip = i_instr_addr;
                d.dp = i_oper_addr;
            end
        end

        // the pin follows the summary bit; only the host decides when to trap
        d.error_b = !d.sw[`SW_ERR_SUM];

        // read data valid for the one cycle after the strobe; reads have no side effect
        if (i_rd) begin
            case (i_addr)
                `OFS_CTRL:      d.rdata = {16'h0000, q.cw};
                `OFS_STATUS:    d.rdata = {16'h0000, q.sw};
                `OFS_TAG:       d.rdata = {16'h0000, q.tw};
                `OFS_INSTR_PTR: d.rdata = q.ip;
                `OFS_DATA_PTR:  d.rdata = q.dp;
                `OFS_LAST_EXC:  d.rdata = {29'h0, q.last_exc};
                default:        d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // hardware reset image differs from initialise in the invalid mask and flags
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign o_rdata       = q.rdata;
    assign o_exc_valid   = q.exc_valid;
    assign o_exc_code    = q.exc_code;
    assign o_use_default = q.use_default;
    assign o_default     = q.default_val;
    assign o_error_b     = q.error_b;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_init_ctrl_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        do_init |=> (q.cw == `CW_INIT))
        else $error("control word not set by initialise");

    chk_init_tag_top: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (do_init && !op_go) |=> (q.tw == `TW_INIT) && (q.sw[13:11] == 3'b000))
        else $error("tag word or stack top wrong after initialise");

    chk_init_flags_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (do_init && !op_go) |=> (q.sw[7:0] == 8'h00) && !o_error_b == 1'b0)
        else $error("flags not cleared by initialise");

    chk_error_pin_summary: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_error_b == !q.sw[`SW_ERR_SUM])
        else $error("error output disagrees with summary bit");

    chk_unmasked_sets_sum: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_exc_valid && !q.cw[o_exc_code - EXC_INVALID]) |-> (q.sw[`SW_ERR_SUM] && !o_error_b))
        else $error("unmasked exception left summary clear");

    chk_snan_invalid: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (op_go && is_snan(i_opnd_a)) |=> (o_exc_valid && o_exc_code == EXC_INVALID))
        else $error("signalling NaN not reported as invalid");

    chk_denorm_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_exc_valid && o_exc_code == EXC_DENORM) |-> q.sw[1] && !o_use_default)
        else $error("denormal report without flag");

    chk_abort_keeps_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_op_valid && i_op_abort) |=> ($stable(q.ip) && $stable(q.dp) && !o_exc_valid))
        else $error("aborted instruction changed the pointers");

    chk_read_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !$past(i_rd) |-> (o_rdata == 32'h0000_0000))
        else $error("read data outside its cycle");

endmodule : fpu_exception_and_init_state

// >>> testbench/host_model.sv
// behavioural host cpu that turns the coprocessor error output into fault vector 16 and emulated or task-switch escapes into vector 7
`timescale 1ns/10ps

module host_model (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // coprocessor error and instruction stream
    input  wire logic i_error_b,
    input  wire logic i_escape,
    input  wire logic i_nowait,
    input  wire logic i_emulate,
    input  wire logic i_task_sw,
    // fault vectors raised
    output logic      o_vec16,
    output logic      o_vec7
);
    // a pending error is taken only at a later waiting escape, so no-wait control ops never fault on it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_vec16 <= 1'b0;
            o_vec7  <= 1'b0;
        end else begin
            o_vec7  <= i_escape && (i_emulate || i_task_sw);
            o_vec16 <= i_escape && !i_nowait && !i_error_b && !i_emulate && !i_task_sw;
        end
    end
endmodule : host_model

// >>> testbench/tb.sv
// self-checking bench for the coprocessor exception and initial state block
`timescale 1ns/10ps

module tb;
    import fpu_exc_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, v = 1'b0, escape_instruction = 1'b0, nw = 1'b0;
    logic [7:0]  f = 8'h00, addr = 8'h00;
    logic [31:0] wd = '0, rdata, ia = '0, oa = 32'h0000_8000, p, q;
    logic [79:0] a = '0, b = '0, dflt;
    fmt_t        fm = FMT_EXTENDED;
    exc_t        code;
    logic        ev, ud, err_b, vec16, vec7;
    int          fails = 0, num_checks = 0;
    localparam logic [79:0] one = 80'h3FFF_8000_0000_0000_0000;
    localparam logic [79:0] den = 80'h0000_0000_0000_0000_0001;
    localparam logic [79:0] snan = 80'h7FFF_A000_0000_0000_0000;

    // ------------------------------------------------------------
    // design and host
    // ------------------------------------------------------------
    fpu_exception_and_init_state fpu_exception_and_init_state_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_op_valid(v), .i_op_abort(f[7]), .i_op_div(f[6]), .i_op_indet(f[5]), .i_push(1'b0), .i_pop(f[4]),
        .i_opnd_a(a), .i_opnd_b(b), .i_dst_fmt(fm), .i_res_sign(1'b0), .i_res_huge(f[3]), .i_res_tiny(f[2]),
        .i_res_lossy(f[1]), .i_res_inexact(f[0]), .i_instr_addr(ia), .i_oper_addr(oa), .i_busy(1'b0),
        .o_exc_valid(ev), .o_exc_code(code), .o_use_default(ud), .o_default(dflt), .o_error_b(err_b));
    host_model host_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_error_b(err_b), .i_escape(escape_instruction),
        .i_nowait(nw), .i_emulate(1'b0), .i_task_sw(1'b0), .o_vec16(vec16), .o_vec7(vec7));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= ad;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe, so they are sampled just after that edge
    task rd_reg(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("register", 80'(rdata & m), 80'(exp));
    endtask : rd_reg
    // addresses are handed through untouched, whatever mode the host runs
    task op(input logic [7:0] fl, input logic [79:0] xa, input logic [79:0] xb, input fmt_t xf,
            input exc_t ex, input logic ude);
        @(posedge clk);
        v <= 1'b1;
        f <= fl;
        a <= xa;
        b <= xb;
        fm <= xf;
        ia <= ia + 32'h0000_0010;
        oa <= oa + 32'h0000_0010;
        @(posedge clk);
        v <= 1'b0;
        #1 chk("exc valid", 80'(ev), 80'(ex != EXC_NONE));
        if (ex != EXC_NONE)
            chk("exc code", 80'(code), 80'(ex));
        chk("use default", 80'(ud), 80'(ude));
    endtask : op
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // clock, watchdog and tests
    // ------------------------------------------------------------
    initial forever #10 clk = ~clk;
    initial begin
        #100000;
        fails++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(8'h00, 32'hFFFF_FFFF, 32'h0000_037E);
        rd_reg(8'h04, 32'hFFFF_B8FF, 32'h0000_0081);
        chk("error out", 80'(err_b), 80'h0);
        $display("reset test done");
        wr_reg(8'h14, 32'h0000_0001);
        rd_reg(8'h00, 32'hFFFF_FFFF, 32'h0000_037F);
        rd_reg(8'h04, 32'hFFFF_B8FF, 32'h0000_0000);
        rd_reg(8'h08, 32'hFFFF_FFFF, 32'h0000_FFFF);
        chk("error out", 80'(err_b), 80'h1);
        $display("initialise test done");
        op(8'h10, one, one, FMT_EXTENDED, EXC_INVALID, 1'b1);
        rd_reg(8'h04, 32'h0000_02FF, 32'h0000_0041);
        op(8'h29, one, one, FMT_INT16, EXC_INVALID, 1'b1);
        chk("default", dflt, 80'h8000);
        op(8'h00, snan, one, FMT_EXTENDED, EXC_INVALID, 1'b1);
        chk("default", dflt, 80'hFFFF_C000_0000_0000_0000);
        op(8'h40, one, '0, FMT_EXTENDED, EXC_ZERODIV, 1'b1);
        chk("default", dflt, 80'h7FFF_8000_0000_0000_0000);
        op(8'h08, one, one, FMT_DOUBLE, EXC_OVERFLOW, 1'b1);
        chk("default", dflt, 80'h7FF0_0000_0000_0000);
        op(8'h04, one, one, FMT_EXTENDED, EXC_NONE, 1'b0);
        op(8'h07, one, one, FMT_EXTENDED, EXC_UNDERFL, 1'b0);
        op(8'h01, one, one, FMT_EXTENDED, EXC_INEXACT, 1'b0);
        op(8'h01, den, one, FMT_EXTENDED, EXC_DENORM, 1'b0);
        $display("masked test done");
        wr_reg(8'h14, 32'h0000_0001);
        wr_reg(8'h00, 32'h0000_037B);
        op(8'h00, one, one, FMT_EXTENDED, EXC_NONE, 1'b0);
        p = ia;
        op(8'hC0, one, '0, FMT_EXTENDED, EXC_NONE, 1'b0);
        rd_reg(8'h0C, 32'hFFFF_FFFF, p);
        op(8'h40, one, '0, FMT_EXTENDED, EXC_ZERODIV, 1'b0);
        chk("error out", 80'(err_b), 80'h0);
        p = ia;
        q = oa;
        op(8'h00, one, one, FMT_EXTENDED, EXC_NONE, 1'b0);
        rd_reg(8'h04, 32'h0000_00FF, 32'h0000_0084);
        rd_reg(8'h0C, 32'hFFFF_FFFF, p);
        rd_reg(8'h10, 32'hFFFF_FFFF, q);
        // a no-wait escape must pass a pending error by, a waiting one must trap
        @(posedge clk);
        escape_instruction <= 1'b1;
        nw <= 1'b1;
        @(posedge clk);
        nw <= 1'b0;
        #1 chk("vec16", 80'(vec16), 80'h0);
        @(posedge clk);
        escape_instruction <= 1'b0;
        #1 chk("vec16", 80'(vec16), 80'h1);
        chk("vec7", 80'(vec7), 80'h0);
        $display("unmasked test done");
        test_done;
    end
endmodule : tb
